// >>> shared/opdec_pkg.sv
// Functional notes
// - Access bit clear uses access RAM; set uses bank.
// - Destination bit picks accumulator or file register.
// - Three-bit field selects bit zero through seven.
// - File operand is 8-bit address or pointer designator.
// - Moves carry 7-bit source and destination offsets.
// - Literal decodes as 8, 12 or 20 bits.
// - Relative offsets signed; direct targets are absolute.
// - Pointer mode: none, post-inc, post-dec, pre-inc.
// - Table pointer 21 bits; table latch 8 bits.
// - Fast bit saves shadows; else untouched.
// - Indexed address adds 7-bit unsigned offset.
// - Five status flags; only declared ones change.
// - Clear-file writes zero and sets null flag.
// - Watchdog kick clears counter, postscaler, sets flags.
`default_nettype none
package opdec_pkg;
    // AXI4-Lite register byte offsets.
    localparam logic [7:0]  OFS_INSN     = 8'h00;   // Instruction word to decode and execute.
    localparam logic [7:0]  OFS_BANK     = 8'h04;   // Bank select, low four bits.
    localparam logic [7:0]  OFS_FIELDS   = 8'h08;   // Decoded operand fields.
    localparam logic [7:0]  OFS_STATUS   = 8'h0C;   // Flags and watchdog status.
    localparam logic [7:0]  OFS_TABPTR   = 8'h10;   // Table pointer.
    localparam logic [7:0]  OFS_TBLLAT   = 8'h14;   // Table latch.
    localparam logic [7:0]  OFS_EFFADDR  = 8'h18;   // Effective file address.
    localparam logic [7:0]  OFS_LITERAL  = 8'h1C;   // Decoded literal and offset.
    localparam logic [7:0]  OFS_INDEX    = 8'h20;   // Indirect base and offsets.
    // Opcode patterns.
    localparam logic [6:0]  CLEAR_PAT    = 7'h35;   // Upper seven bits 0110 101.
    localparam logic [15:0] KICK_PAT     = 16'h0004; // Watchdog kick word.
    localparam logic [11:0] ZERO_VAL     = 12'h000;  // Cleared value.
    localparam logic [3:0]  BANK_RST     = 4'h0;
    localparam logic [20:0] TABPTR_RST   = 21'h0_0000;
    localparam logic [7:0]  WDT_RST      = 8'h00;
    // Pointer update modes.
    typedef enum logic [1:0] {
        PTR_KEEP = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC = 2'b11
    } ptr_mode_t;
    // Decoded operand fields.
    typedef struct packed {
        logic       access_sel;   // Access bit.
        logic       dest_sel;     // Destination bit.
        logic [2:0] bit_pos;      // Bit address.
        logic [7:0] file_addr;    // Short file address.
        logic [1:0] ptr_desig;    // Indirect pointer designator.
        logic       fast_sel;     // Fast call/return select.
        ptr_mode_t  ptr_mode;     // Table pointer mode.
    } fields_t;
    // Status flags.
    typedef struct packed {
        logic neg;
        logic signed_excess_flag;
        logic result_null_flag;
        logic half_carry_flag;
        logic carry;
    } flags_t;
endpackage
`default_nettype wire

// >>> verilog/opcode_field_decode.sv
`default_nettype none
module opcode_field_decode (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // AXI4-Lite write address.
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Register file write port for cleared registers.
    output logic             rf_we,
    output logic [11:0]      rf_addr,
    output logic [7:0]       rf_wdata
);
    // Captured write channels; address and data may arrive in either order.
    logic        aw_held_q;
    logic [7:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    // Architectural state.
    logic [15:0] insn_q;                        // Last instruction word.
    logic [3:0]  bank_q;                        // Bank select register.
    opdec_pkg::flags_t flags_q;                 // ALU status flags.
    logic        wdt_expiry_n_q;                // Active-low watchdog expiry flag.
    logic        sleep_n_q;                     // Active-low sleep entry flag.
    logic [7:0]  wdt_count_q;                   // Watchdog counter.
    logic [3:0]  wdt_post_q;                    // Watchdog postscaler.
    logic [20:0] tab_ptr_q;                     // Table pointer.
    logic [7:0]  tbllat_q;                      // Table latch.
    logic        shadow_valid_q;                // Shadow registers loaded.
    logic [7:0]  shadow_q;                      // Shadowed status copy.
    logic [11:0] ptr_base_q [4];                // Indirect pointer bases.
    // Decode outputs.
    opdec_pkg::fields_t fld;
    logic [11:0] eff_addr;
    logic [19:0] lit20;
    logic [11:0] lit12;
    logic [7:0]  lit8;
    logic [10:0] rel_off;
    logic [6:0]  src_off;
    logic [6:0]  dst_off;
    logic [11:0] idx_src;
    logic [11:0] idx_dst;
    logic        is_clear;
    logic        is_kick;
    logic        exec_q;                        // One-cycle execute strobe.

    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;
    assign s_axi_arready = !s_axi_rvalid;

    // Hold write address until paired with data.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    // Hold write data until paired with address.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            w_held_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    // Write response; unmapped addresses answer DECERR but store nothing.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_q == opdec_pkg::OFS_INSN || aw_addr_q == opdec_pkg::OFS_BANK ||
                             aw_addr_q == opdec_pkg::OFS_TABPTR || aw_addr_q == opdec_pkg::OFS_TBLLAT ||
                             aw_addr_q == opdec_pkg::OFS_INDEX) ? 2'b00 : 2'b11;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Field extraction; bit 15 belongs to no field but still steers the clear and kick matches.
    always_comb begin
        fld.access_sel = insn_q[8];
        fld.dest_sel   = insn_q[9];
        fld.bit_pos    = insn_q[11:9];
        fld.file_addr  = insn_q[7:0];
        fld.ptr_desig  = insn_q[5:4];
        fld.fast_sel   = insn_q[0];
        fld.ptr_mode   = opdec_pkg::ptr_mode_t'(insn_q[1:0]);
    end

    // Literals in three widths and both branch operand forms.
    assign lit8    = insn_q[7:0];
    assign lit12   = insn_q[11:0];
    assign lit20   = {lit12, lit8};
    assign rel_off = insn_q[10:0];
    assign src_off = insn_q[6:0];
    assign dst_off = insn_q[14:8];

    // Indexed addressing adds unsigned offsets to the selected pointer base.
    assign idx_src = ptr_base_q[fld.ptr_desig] + {5'h00, src_off};
    assign idx_dst = ptr_base_q[fld.ptr_desig] + {5'h00, dst_off};

    // Access bank upper half maps to SFRs, so access RAM is split at 80h.
    always_comb begin
        if (fld.access_sel) begin
            eff_addr = {bank_q, fld.file_addr};
        end else begin
            eff_addr = {{4{fld.file_addr[7]}}, fld.file_addr};
        end
    end

    // Kick is an exact match; clear matches the upper seven bits, leaving access bit and file address as operands.
    assign is_clear = (insn_q[15:9] == opdec_pkg::CLEAR_PAT);
    assign is_kick = (insn_q == opdec_pkg::KICK_PAT);

    // A write to the instruction register launches one execute cycle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            insn_q <= 16'h0000;
            exec_q <= 1'b0;
        end else begin
            exec_q <= wr_fire && aw_addr_q == opdec_pkg::OFS_INSN;
            if (wr_fire && aw_addr_q == opdec_pkg::OFS_INSN) begin
                insn_q <= w_data_q[15:0];
            end
        end
    end

    // Register-file write is a single-cycle result of the cleared file op.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rf_we    <= 1'b0;
            rf_addr  <= 12'h000;
            rf_wdata <= 8'h00;
        end else begin
            rf_we    <= exec_q && is_clear;
            rf_addr  <= eff_addr;
            rf_wdata <= opdec_pkg::ZERO_VAL[7:0];
        end
    end

    // Only the null flag is touched by the clear op; others keep their value.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flags_q <= '0;
        end else if (exec_q && is_clear) begin
            flags_q.result_null_flag <= 1'b1;
        end
    end

    // Watchdog kick: counter, postscaler and both active-low flags.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wdt_count_q    <= opdec_pkg::WDT_RST;
            wdt_post_q     <= 4'h0;
            wdt_expiry_n_q <= 1'b1;
            sleep_n_q      <= 1'b1;
        end else if (exec_q && is_kick) begin
            wdt_count_q    <= opdec_pkg::WDT_RST;
            wdt_post_q     <= 4'h0;
            wdt_expiry_n_q <= 1'b1;
            sleep_n_q      <= 1'b1;
        end else begin
            wdt_count_q <= wdt_count_q + 8'h01;
            if (wdt_count_q == 8'hFF) begin
                wdt_post_q <= wdt_post_q + 4'h1;
                if (wdt_post_q == 4'hF) begin
                    wdt_expiry_n_q <= 1'b0;
                end
            end
        end
    end

    // Fast-mode shadow: save on an execute that is neither clear nor kick, only when the fast bit is set.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shadow_valid_q <= 1'b0;
            shadow_q       <= 8'h00;
        end else if (exec_q && fld.fast_sel && !is_clear && !is_kick) begin
            shadow_valid_q <= 1'b1;
            shadow_q       <= {3'b000, flags_q};
        end
    end

    // Bank, table pointer with update mode, latch and pointer bases.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bank_q   <= opdec_pkg::BANK_RST;
            tab_ptr_q <= opdec_pkg::TABPTR_RST;
            tbllat_q <= 8'h00;
            for (int i = 0; i < 4; i++) begin
                ptr_base_q[i] <= 12'h000;
            end
        end else begin
            if (wr_fire && aw_addr_q == opdec_pkg::OFS_BANK && w_strb_q[0]) begin
                bank_q <= w_data_q[3:0];
            end
            if (wr_fire && aw_addr_q == opdec_pkg::OFS_TBLLAT && w_strb_q[0]) begin
                tbllat_q <= w_data_q[7:0];
            end
            if (wr_fire && aw_addr_q == opdec_pkg::OFS_INDEX) begin
                ptr_base_q[w_data_q[13:12]] <= w_data_q[11:0];
            end
            if (wr_fire && aw_addr_q == opdec_pkg::OFS_TABPTR) begin
                tab_ptr_q <= w_data_q[20:0];
            end else if (exec_q && !is_clear && !is_kick) begin
                case (fld.ptr_mode)
                    opdec_pkg::PTR_KEEP:     tab_ptr_q <= tab_ptr_q;
                    opdec_pkg::PTR_POST_INC: tab_ptr_q <= tab_ptr_q + 21'h00_0001;
                    opdec_pkg::PTR_POST_DEC: tab_ptr_q <= tab_ptr_q - 21'h00_0001;
                    opdec_pkg::PTR_PRE_INC:  tab_ptr_q <= tab_ptr_q + 21'h00_0001;
                    default:                 tab_ptr_q <= tab_ptr_q;
                endcase
            end
        end
    end

    // Read channel; one outstanding read, data registered.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                opdec_pkg::OFS_INSN:    s_axi_rdata <= {16'h0000, insn_q};
                opdec_pkg::OFS_BANK:    s_axi_rdata <= {28'h000_0000, bank_q};
                opdec_pkg::OFS_FIELDS:  s_axi_rdata <= {11'h000, shadow_valid_q, is_kick, is_clear, fld};
                opdec_pkg::OFS_STATUS:  s_axi_rdata <= {13'h0000, wdt_post_q, wdt_count_q,
                                                        sleep_n_q, wdt_expiry_n_q, flags_q};
                opdec_pkg::OFS_TABPTR:  s_axi_rdata <= {11'h000, tab_ptr_q};
                opdec_pkg::OFS_TBLLAT:  s_axi_rdata <= {24'h00_0000, tbllat_q};
                opdec_pkg::OFS_EFFADDR: s_axi_rdata <= {4'h0, idx_dst, 4'h0, eff_addr};
                opdec_pkg::OFS_LITERAL: s_axi_rdata <= {1'b0, rel_off, lit20};
                opdec_pkg::OFS_INDEX:   s_axi_rdata <= {1'b0, dst_off, 1'b0, src_off, 4'h0, idx_src};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b11;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Clear-file op writes the register one cycle after execute.
    a_clear_write: assert property (@(posedge clock) disable iff (rst)
        exec_q && is_clear |=> rf_we && rf_wdata == 8'h00)
        else $error("clear op did not write zero");
    // Kick resets the watchdog counter.
    a_kick_clear: assert property (@(posedge clock) disable iff (rst)
        exec_q && is_kick |=> wdt_count_q == 8'h00 && wdt_expiry_n_q && sleep_n_q)
        else $error("kick did not clear watchdog");
    // No stray file writes.
    a_write_cause: assert property (@(posedge clock) disable iff (rst)
        rf_we |-> $past(exec_q) && $past(is_clear))
        else $error("file write without clear op");
    // Banked address uses bank.
    a_bank_addr: assert property (@(posedge clock) disable iff (rst)
        fld.access_sel |-> eff_addr[11:8] == bank_q)
        else $error("banked address wrong");
    // Null flag set after clear.
    a_null_flag: assert property (@(posedge clock) disable iff (rst)
        exec_q && is_clear |=> flags_q.result_null_flag)
        else $error("null flag not set");
    // Post-increment steps pointer.
    a_ptr_inc: assert property (@(posedge clock) disable iff (rst)
        exec_q && !is_clear && !is_kick && fld.ptr_mode == opdec_pkg::PTR_POST_INC && !wr_fire
        |=> tab_ptr_q == $past(tab_ptr_q) + 21'h00_0001)
        else $error("pointer not incremented");
    // Shadow untouched when fast bit clear.
    a_shadow_hold: assert property (@(posedge clock) disable iff (rst)
        exec_q && !fld.fast_sel |=> $stable(shadow_q))
        else $error("shadow changed without fast bit");
    // Execute strobe is one cycle.
    a_exec_pulse: assert property (@(posedge clock) disable iff (rst)
        exec_q |=> !exec_q)
        else $error("execute longer than one cycle");
endmodule
`default_nettype wire

// >>> sim/test_mcu_opcode_field_decode.sv
`default_nettype none
module test_mcu_opcode_field_decode;
    timeunit 1ns;
    timeprecision 1ns;
    // Clock, reset and bus master signals driven by the bench.
    logic        clock, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    // Outputs of the design.
    logic        awready, wready, bvalid, arready, rvalid, rf_we;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [11:0] rf_addr;
    logic [7:0]  rf_wdata;
    // Bookkeeping of the bench.
    int          num_errors = 0, checked = 0, rf_count = 0, i;
    logic [11:0] rf_last;
    logic [7:0]  rf_data, f;
    logic [31:0] seed, d, insn;
    logic [1:0]  r, m;
    logic [3:0]  bank;
    logic [20:0] p;
    logic        a;

    opcode_field_decode u_dut (
        .clock(clock), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .rf_we(rf_we), .rf_addr(rf_addr), .rf_wdata(rf_wdata)
    );

    // Free-running 50 ns clock.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Every register-file write pulse is counted, so a double or missing pulse shows up.
    always @(posedge clock) begin
        if (rf_we === 1'b1) begin
            rf_count <= rf_count + 1;
            rf_last  <= rf_addr;
            rf_data  <= rf_wdata;
        end
    end

    // Repeatable xorshift source; the seed is fixed so a failure can be replayed.
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    // Expected register address of a clear: access RAM splits at 80h, else the bank is prefixed.
    function automatic logic [11:0] exp_addr(input logic acc, input logic [7:0] fa, input logic [3:0] bk);
        if (acc) begin
            return {bk, fa};
        end else if (fa < 8'h80) begin
            return {4'h0, fa};
        end
        return {4'hF, fa};
    endfunction

    // Expected table pointer after one update; pre- and post-increment both advance by one.
    function automatic logic [20:0] exp_ptr(input logic [1:0] md, input logic [20:0] pt);
        case (md)
            2'b00: return pt;
            2'b10: return pt - 21'h0_0001;
            default: return pt + 21'h0_0001;
        endcase
    endfunction

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test;
        $display("Mismatches: %0d, comparisons: %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // One comparison with case equality, so unknowns never match.
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
            num_errors++;
        end
    endtask

    // A wait that ran out of its bound ends the run as a mismatch.
    task automatic wait_fail(input string name);
        $display("CHECK FAILED %s expected handshake seen none", name);
        num_errors++;
        end_of_test;
    endtask

    // Write cycle: address and data offered together, each released once taken.
    task automatic axi_write(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] resp);
        logic aw_done, w_done;
        int   n;
        aw_done = 1'b0;
        w_done  = 1'b0;
        awaddr  <= addr;
        wdata   <= data;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 50 && !(aw_done && w_done); n++) begin
            @(posedge clock);
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_done && w_done)) wait_fail("write address");
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (bvalid === 1'b1) break;
        end
        if (n == 50) wait_fail("write response");
        resp = bresp;
        bready <= 1'b0;
    endtask

    // Read cycle: address held until taken, then rready held until data arrives.
    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] resp);
        int n;
        araddr  <= addr;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (arready === 1'b1) break;
        end
        if (n == 50) wait_fail("read address");
        arvalid <= 1'b0;
        rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clock);
            if (rvalid === 1'b1) break;
        end
        if (n == 50) wait_fail("read data");
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b0_0000;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        seed = 32'd98158;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        // Reset values and unmapped places.
        axi_read(opdec_pkg::OFS_BANK, d, r);
        check("bank reset", 32'h0000_0000, d);
        axi_read(opdec_pkg::OFS_TABPTR, d, r);
        check("pointer reset", 32'h0000_0000, d);
        axi_read(8'h40, d, r);
        check("unmapped read resp", 32'h0000_0003, {30'h0, r});
        axi_write(8'h44, 32'h1234_5678, r);
        check("unmapped write resp", 32'h0000_0003, {30'h0, r});
        // Clears with random bank, access bit and address, corners first.
        for (i = 0; i < 12; i++) begin
            seed = next_rand(seed);
            bank = seed[3:0];
            a = (i < 2) ? 1'b0 : seed[4];
            f = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : seed[15:8];
            axi_write(opdec_pkg::OFS_BANK, {seed[31:4], bank}, r);
            check("bank write resp", 32'h0000_0000, {30'h0, r});
            axi_read(opdec_pkg::OFS_BANK, d, r);
            check("bank readback", {28'h0, bank}, d & 32'h0000_000F);
            axi_write(opdec_pkg::OFS_INSN, {16'h0000, 7'h35, a, f}, r);
            repeat (3) @(posedge clock);
            check("clear pulse count", i + 1, rf_count);
            check("clear address", {20'h0, exp_addr(a, f, bank)}, {20'h0, rf_last});
            check("clear data", 32'h0000_0000, {24'h0, rf_data});
            axi_read(opdec_pkg::OFS_STATUS, d, r);
            check("null flag", 32'h0000_0004, d & 32'h0000_0004);
        end
        // Table pointer modes, with wrap corners and random pointers.
        for (i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            m = i[1:0];
            p = (i >= 4) ? seed[20:0] : (m == 2'b10) ? 21'h0_0000 : 21'h1F_FFFF;
            insn = {16'h0000, 1'b1, seed[22:16], seed[7:2], m};
            axi_write(opdec_pkg::OFS_TABPTR, {11'h0, p}, r);
            axi_write(opdec_pkg::OFS_INSN, insn, r);
            repeat (3) @(posedge clock);
            axi_read(opdec_pkg::OFS_TABPTR, d, r);
            check("pointer update", {11'h0, exp_ptr(m, p)}, d & 32'h001F_FFFF);
            axi_read(opdec_pkg::OFS_FIELDS, d, r);
            check("mode field", {30'h0, m}, d & 32'h0000_0003);
            check("fast field", {29'h0, insn[0], 2'b00}, d & 32'h0000_0004);
            check("shadow loaded", {11'h0, i >= 1, 20'h0}, d & 32'h0010_0000);
            check("no stray clear", 12, rf_count);
        end
        // Table latch keeps eight bits only.
        seed = next_rand(seed);
        axi_write(opdec_pkg::OFS_TBLLAT, seed, r);
        axi_read(opdec_pkg::OFS_TBLLAT, d, r);
        check("latch width", {24'h0, seed[7:0]}, d);
        // Indexed addresses from pointer base one; the source sum wraps within twelve bits.
        axi_write(opdec_pkg::OFS_INDEX, 32'h0000_1FF0, r);
        axi_write(opdec_pkg::OFS_INSN, 32'h0000_2A15, r);
        axi_read(opdec_pkg::OFS_INDEX, d, r);
        check("indexed source", {1'b0, 7'h2A, 1'b0, 7'h15, 4'h0, 12'hFF0 + 12'h015}, d);
        axi_read(opdec_pkg::OFS_EFFADDR, d, r);
        check("indexed dest", {4'h0, 12'hFF0 + 12'h02A, 4'h0, 12'h015}, d);
        // The free-running watchdog times out first, so the kick has the expiry flag to restore.
        repeat (4200) @(posedge clock);
        axi_read(opdec_pkg::OFS_STATUS, d, r);
        check("expiry before kick", 32'h0000_0000, d & 32'h0000_0020);
        // Watchdog kick sets both active-low flags, clears the postscaler and writes no register.
        axi_write(opdec_pkg::OFS_INSN, 32'h0000_0004, r);
        repeat (3) @(posedge clock);
        axi_read(opdec_pkg::OFS_STATUS, d, r);
        check("kick flags", 32'h0000_0060, d & 32'h0007_8060);
        check("kick no write", 12, rf_count);
        end_of_test;
    end

    // Overall limit in case a wait escapes its own bound.
    initial begin
        repeat (100000) @(posedge clock);
        num_errors++;
        end_of_test;
    end
endmodule
`default_nettype wire
